/* File: core/be8s_pkg.sv */
/*
 * Shared types and constants for the big-endian byte lane steering block,
 * together with the combinational lane multiplexer that the top module uses.
 * Assumes a 32-bit little-endian memory-mapped bus with four byte lanes and
 * a core that issues byte, halfword and word loads and stores.
 */

package be8s_pkg;

    // ========================================================================
    // Widths and constants
    // ========================================================================
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned LANE_W = 8;
    localparam int unsigned LANES = 4;
    localparam logic [3:0] BE_NONE = 4'h0;
    localparam logic [3:0] BE_BYTE = 4'h1;
    localparam logic [3:0] BE_HALF = 4'h3;
    localparam logic [3:0] BE_WORD = 4'hF;
    localparam logic [1:0] OFS_MASK_HALF = 2'h2;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;

    // ========================================================================
    // Types
    // ========================================================================
    typedef enum logic [1:0] {
        BE8S_SZ_BYTE = 2'b00,
        BE8S_SZ_HALF = 2'b01,
        BE8S_SZ_WORD = 2'b10
    } be8s_size_t;

    typedef struct packed {
        logic write;
        be8s_size_t size;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } be8s_req_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] byteenable;
        logic [DATA_W-1:0] writedata;
    } be8s_bus_t;

    // ========================================================================
    // Lane helpers
    // ========================================================================
    // Lane n of a bus word carries byte offset n of the addressed word.
    function automatic logic [7:0] be8s_lane(input logic [31:0] word, input logic [1:0] idx);
        be8s_lane = word[{idx, 3'b000} +: 8];
    endfunction

    // Halfwords are forced to an even offset; words to offset zero.
    function automatic logic [1:0] be8s_align(input be8s_size_t size, input logic [1:0] ofs);
        unique case (size)
            BE8S_SZ_BYTE: be8s_align = ofs;
            BE8S_SZ_HALF: be8s_align = ofs & OFS_MASK_HALF;
            default: be8s_align = 2'b00;
        endcase
    endfunction

endpackage

`timescale 1ns/1ps

module be8s_lane_mux (
    input wire be8s_pkg::be8s_size_t size,
    input wire logic [1:0] offset,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] bus_rdata,
    output logic [31:0] bus_wdata,
    output logic [3:0] byteenable,
    output logic [31:0] reg_rdata
);

    logic [1:0] ofs;
    logic [4:0] sh;

    always_comb begin
        ofs = be8s_pkg::be8s_align(size, offset);
        sh = {ofs, 3'b000};
        bus_wdata = be8s_pkg::DATA_RST;
        reg_rdata = be8s_pkg::DATA_RST;
        byteenable = be8s_pkg::BE_NONE;
        unique case (size)
            be8s_pkg::BE8S_SZ_BYTE: begin
                // A single lane needs no reordering.
                bus_wdata = 32'(reg_wdata[7:0]) << sh; // RQ2 RQ7
                byteenable = be8s_pkg::BE_BYTE << ofs; // RQ8
                reg_rdata = {24'h00_0000, be8s_pkg::be8s_lane(bus_rdata, ofs)}; // RQ7
            end
            be8s_pkg::BE8S_SZ_HALF: begin
                // Most significant byte sits on the lower-addressed lane.
                bus_wdata = 32'({reg_wdata[7:0], reg_wdata[15:8]}) << sh; // RQ3
                byteenable = be8s_pkg::BE_HALF << ofs; // RQ8
                reg_rdata = {16'h0000, be8s_pkg::be8s_lane(bus_rdata, ofs),
                             be8s_pkg::be8s_lane(bus_rdata, ofs + 2'h1)}; // RQ5
            end
            default: begin
                bus_wdata = {reg_wdata[7:0], reg_wdata[15:8],
                             reg_wdata[23:16], reg_wdata[31:24]}; // RQ4 RQ1
                byteenable = be8s_pkg::BE_WORD; // RQ8
                reg_rdata = {be8s_pkg::be8s_lane(bus_rdata, 2'h0),
                             be8s_pkg::be8s_lane(bus_rdata, 2'h1),
                             be8s_pkg::be8s_lane(bus_rdata, 2'h2),
                             be8s_pkg::be8s_lane(bus_rdata, 2'h3)}; // RQ5
            end
        endcase
    end

endmodule

/* File: core/be8s_steer.sv */
/*
 * Top of the big-endian byte lane steering block. Takes one load or store
 * at a time from the core, places it on the little-endian bus lanes with
 * matching byte enables, waits out the bus wait request, and returns load
 * data reassembled in network byte order.
 * Assumes the bus samples read or write with BUS_WAIT low as completion and
 * presents read data in that same cycle.
 */

// Overview of operation
// RQ1: Bus lane zero holds byte offset zero.
// RQ2: Byte store drives only its addressed lane.
// RQ3: Halfword store: high byte on lower lane.
// RQ4: Word store reverses register bytes onto bus.
// RQ5: Loads place lowest-address byte most significant.
// RQ6: Swap applies to every address, peripherals included.
// RQ7: Byte accesses pass through without reordering.
// RQ8: Byte enables match the lanes driven.

`timescale 1ns/1ps

module be8s_steer (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CORE_VALID,
    input wire be8s_pkg::be8s_req_t CORE_REQ,
    output logic CORE_READY,
    output logic CORE_DONE,
    output logic [31:0] CORE_RDATA,
    output be8s_pkg::be8s_bus_t BUS_CMD,
    input wire logic BUS_WAIT,
    input wire logic [31:0] BUS_RDATA
);

    // ========================================================================
    // State
    // ========================================================================
    typedef enum logic [0:0] {
        BE8S_IDLE = 1'b0,
        BE8S_BUSY = 1'b1
    } be8s_fsm_t;

    typedef struct packed {
        be8s_fsm_t fsm;
        be8s_pkg::be8s_size_t size;
        logic [1:0] offset;
        be8s_pkg::be8s_bus_t bus;
        logic ready;
        logic done;
        logic [31:0] rdata;
    } be8s_state_t;

    be8s_state_t st_q;
    be8s_state_t st_d;

    logic accept;
    be8s_pkg::be8s_size_t mux_size;
    logic [1:0] mux_ofs;
    logic [31:0] mux_wdata;
    logic [3:0] mux_be;
    logic [31:0] mux_rdata;

    assign accept = CORE_VALID && st_q.ready;
    // While idle the mux steers the incoming store; while busy it unpacks
    // the load using the size and offset latched at acceptance.
    assign mux_size = (st_q.fsm == BE8S_IDLE) ? CORE_REQ.size : st_q.size;
    assign mux_ofs = (st_q.fsm == BE8S_IDLE) ? CORE_REQ.addr[1:0] : st_q.offset;

    // ========================================================================
    // Lane steering
    // ========================================================================
    be8s_lane_mux u_mux (
        .size(mux_size),
        .offset(mux_ofs),
        .reg_wdata(CORE_REQ.wdata),
        .bus_rdata(BUS_RDATA),
        .bus_wdata(mux_wdata),
        .byteenable(mux_be),
        .reg_rdata(mux_rdata)
    );

    // ========================================================================
    // Control
    // ========================================================================
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        unique case (st_q.fsm)
            BE8S_IDLE: begin
                if (accept) begin
                    st_d.fsm = BE8S_BUSY;
                    st_d.ready = 1'b0;
                    st_d.size = CORE_REQ.size;
                    st_d.offset = CORE_REQ.addr[1:0];
                    st_d.bus.read = !CORE_REQ.write;
                    st_d.bus.write = CORE_REQ.write;
                    // No address range is exempt from the swap.
                    st_d.bus.addr = {CORE_REQ.addr[31:2], 2'b00}; // RQ6
                    st_d.bus.byteenable = mux_be; // RQ8
                    st_d.bus.writedata = CORE_REQ.write ? mux_wdata
                                                        : be8s_pkg::DATA_RST; // RQ2 RQ3 RQ4
                end
            end
            BE8S_BUSY: begin
                if (!BUS_WAIT) begin
                    st_d.fsm = BE8S_IDLE;
                    st_d.ready = 1'b1;
                    st_d.done = 1'b1;
                    st_d.bus.read = 1'b0;
                    st_d.bus.write = 1'b0;
                    if (st_q.bus.read) begin
                        st_d.rdata = mux_rdata; // RQ5 RQ7
                    end
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '{fsm: BE8S_IDLE, size: be8s_pkg::BE8S_SZ_BYTE, offset: 2'b00,
                      bus: '{read: 1'b0, write: 1'b0, addr: be8s_pkg::ADDR_RST,
                             byteenable: be8s_pkg::BE_NONE,
                             writedata: be8s_pkg::DATA_RST},
                      ready: 1'b1, done: 1'b0, rdata: be8s_pkg::DATA_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign CORE_READY = st_q.ready;
    assign CORE_DONE = st_q.done;
    assign CORE_RDATA = st_q.rdata;
    assign BUS_CMD = st_q.bus;

    // ========================================================================
    // Checks
    // ========================================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);

    logic ld_done;
    assign ld_done = (st_q.fsm == BE8S_BUSY) && st_q.bus.read && !BUS_WAIT;

    lane_zero_a: assert property ( // RQ1
        accept && CORE_REQ.write && CORE_REQ.size == be8s_pkg::BE8S_SZ_BYTE
        && CORE_REQ.addr[1:0] == 2'b00
        |=> BUS_CMD.byteenable == 4'h1 && BUS_CMD.writedata[7:0] == $past(CORE_REQ.wdata[7:0]))
        else $error("byte offset zero not on the lowest lane");

    byte_lane_a: assert property ( // RQ2
        accept && CORE_REQ.write && CORE_REQ.size == be8s_pkg::BE8S_SZ_BYTE
        |=> (BUS_CMD.writedata >> {$past(CORE_REQ.addr[1:0]), 3'b000})
            == 32'($past(CORE_REQ.wdata[7:0])))
        else $error("byte store not confined to its lane");

    half_order_a: assert property ( // RQ3
        accept && CORE_REQ.write && CORE_REQ.size == be8s_pkg::BE8S_SZ_HALF
        && CORE_REQ.addr[1:0] == 2'b10
        |=> BUS_CMD.writedata[23:16] == $past(CORE_REQ.wdata[15:8])
            && BUS_CMD.writedata[31:24] == $past(CORE_REQ.wdata[7:0])
            && BUS_CMD.byteenable == 4'hC)
        else $error("halfword store lanes in wrong order");

    word_rev_a: assert property ( // RQ4
        accept && CORE_REQ.write && CORE_REQ.size == be8s_pkg::BE8S_SZ_WORD
        |=> BUS_CMD.writedata[7:0] == $past(CORE_REQ.wdata[31:24])
            && BUS_CMD.writedata[31:24] == $past(CORE_REQ.wdata[7:0]))
        else $error("word store not byte reversed");

    word_load_a: assert property ( // RQ5
        ld_done && st_q.size == be8s_pkg::BE8S_SZ_WORD
        |=> CORE_DONE && CORE_RDATA == {$past(BUS_RDATA[7:0]), $past(BUS_RDATA[15:8]),
                                        $past(BUS_RDATA[23:16]), $past(BUS_RDATA[31:24])})
        else $error("word load not in network order");

    half_load_a: assert property ( // RQ5
        ld_done && st_q.size == be8s_pkg::BE8S_SZ_HALF && st_q.offset[1]
        |=> CORE_RDATA == {16'h0000, $past(BUS_RDATA[23:16]), $past(BUS_RDATA[31:24])})
        else $error("upper halfword load not in network order");

    no_exempt_a: assert property ( // RQ6
        accept && CORE_REQ.write && CORE_REQ.size == be8s_pkg::BE8S_SZ_WORD
        |=> BUS_CMD.addr == {$past(CORE_REQ.addr[31:2]), 2'b00}
            && BUS_CMD.writedata[15:8] == $past(CORE_REQ.wdata[23:16]))
        else $error("word swap missing for some address");

    byte_pass_a: assert property ( // RQ7
        ld_done && st_q.size == be8s_pkg::BE8S_SZ_BYTE
        |=> CORE_RDATA == 32'($past(BUS_RDATA) >> {$past(st_q.offset), 3'b000} & 32'h0000_00FF))
        else $error("byte load reordered");

    be_match_a: assert property ( // RQ8
        accept |=> BUS_CMD.read != BUS_CMD.write
            && $countones(BUS_CMD.byteenable) == (($past(CORE_REQ.size) ==
               be8s_pkg::BE8S_SZ_BYTE) ? 1 : ($past(CORE_REQ.size) ==
               be8s_pkg::BE8S_SZ_HALF) ? 2 : 4))
        else $error("byte enables do not match size");

    hold_wait_a: assert property (
        (BUS_CMD.read || BUS_CMD.write) && BUS_WAIT |=> $stable(BUS_CMD))
        else $error("bus command changed under wait");

    // The core may be taken again on the done edge itself, so ready is only
    // promised in the done cycle, not in the one after it.
    done_once_a: assert property (
        CORE_DONE |-> CORE_READY ##1 !CORE_DONE)
        else $error("done held longer than one cycle");

    busy_ready_a: assert property (
        (BUS_CMD.read || BUS_CMD.write) |-> !CORE_READY && !CORE_DONE)
        else $error("core taken while a bus command is open");

    rdata_hold_a: assert property (
        !ld_done |=> $stable(CORE_RDATA))
        else $error("load result changed without a load");

    store_c: cover property (accept && CORE_REQ.write ##1 BUS_WAIT ##1 !BUS_WAIT);
    load_c: cover property (accept && !CORE_REQ.write ##1 ld_done ##1 CORE_DONE);
    half_c: cover property (accept && CORE_REQ.size == be8s_pkg::BE8S_SZ_HALF);
    slow_load_c: cover property (BUS_CMD.read && BUS_WAIT ##1 ld_done);
    byte_load_c: cover property (ld_done && st_q.size == be8s_pkg::BE8S_SZ_BYTE);

endmodule

/* File: tb/be8s_bus_slave.sv */
/*
 * Behavioural memory slave for the lane steering bench: sixteen words,
 * per-lane writes under byte enable and an optional two-cycle wait.
 * Assumes the master holds its command stable while wait_req is high.
 */
`timescale 1ns/1ps
module be8s_bus_slave (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic slow,
    input wire be8s_pkg::be8s_bus_t cmd,
    output logic wait_req,
    output logic [31:0] rdata
);
    // ==========================================================
    // Storage and wait states
    // ==========================================================
    logic [31:0] mem [0:15];
    logic [1:0] cnt_q;
    logic [31:0] junk_q;
    assign wait_req = (cmd.read | cmd.write) & slow & (cnt_q != 2'h2);
    // Outside the completing cycle the read data moves every cycle, so an
    // early or late sample cannot match by luck.
    assign rdata = (cmd.read & ~wait_req) ? mem[cmd.addr[5:2]] : junk_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 2'h0;
            junk_q <= 32'h5A3C_96E1;
        end else begin
            junk_q <= ~{junk_q[0], junk_q[31:1]};
            cnt_q <= wait_req ? cnt_q + 2'h1 : 2'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (cmd.write & ~wait_req) begin
            for (int i = 0; i < 4; i++) begin
                if (cmd.byteenable[i]) begin
                    mem[cmd.addr[5:2]][8*i +: 8] <= cmd.writedata[8*i +: 8];
                end
            end
        end
    end
endmodule

/* File: tb/tb_be8_byte_lane_steering.sv */
/*
 * Self-checking bench for the byte lane steering block.
 * Assumes the behavioural slave model stands on the bus side.
 */
`timescale 1ns/1ps
module tb_be8_byte_lane_steering;
    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic CORE_VALID = 1'b0;
    be8s_pkg::be8s_req_t CORE_REQ = '0;
    logic CORE_READY, CORE_DONE, BUS_WAIT, slow = 1'b0;
    logic [31:0] CORE_RDATA, BUS_RDATA, wr_d, wr_a, rd;
    logic [3:0] wr_be;
    be8s_pkg::be8s_bus_t BUS_CMD;
    int n_errors = 0;
    int checked = 0;
    always #5 CLK = ~CLK;
    be8s_steer u_dut (.CLK(CLK), .RESET_N(RESET_N), .CORE_VALID(CORE_VALID),
        .CORE_REQ(CORE_REQ), .CORE_READY(CORE_READY), .CORE_DONE(CORE_DONE),
        .CORE_RDATA(CORE_RDATA), .BUS_CMD(BUS_CMD), .BUS_WAIT(BUS_WAIT),
        .BUS_RDATA(BUS_RDATA));
    be8s_bus_slave u_slave (.clk(CLK), .reset_n(RESET_N), .slow(slow), .cmd(BUS_CMD),
        .wait_req(BUS_WAIT), .rdata(BUS_RDATA));
    always @(posedge CLK) begin
        if (BUS_CMD.write && !BUS_WAIT) begin
            wr_be <= BUS_CMD.byteenable;
            wr_d <= BUS_CMD.writedata;
            wr_a <= BUS_CMD.addr;
        end
    end
    // ==========================================================
    // Shared tasks
    // ==========================================================
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic op(input logic w, input be8s_pkg::be8s_size_t sz, input logic [31:0] a,
                      input logic [31:0] d);
        int n;
        @(posedge CLK);
        CORE_VALID <= 1'b1;
        CORE_REQ <= '{write: w, size: sz, addr: a, wdata: d};
        @(posedge CLK);
        CORE_VALID <= 1'b0;
        n = 0;
        do begin
            @(posedge CLK);
            #1;
            n++;
        end while (CORE_DONE !== 1'b1 && n < 40);
        check("done", {31'h0, CORE_DONE}, 32'h1);
        rd = CORE_RDATA;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_byte();
        op(1'b1, be8s_pkg::BE8S_SZ_WORD, 32'h0, 32'h0);
        for (int o = 0; o < 4; o++) begin
            op(1'b1, be8s_pkg::BE8S_SZ_BYTE, o, 32'h5555_55A0 + o);
            check("byte be", {28'h0, wr_be}, 32'h1 << o);
            check("byte lane", {24'h0, wr_d[8*o +: 8]}, 32'hA0 + o);
            check("byte addr", wr_a, 32'h0);
        end
        op(1'b0, be8s_pkg::BE8S_SZ_WORD, 32'h0, 32'h0);
        check("word load", rd, 32'hA0A1_A2A3);
        for (int o = 0; o < 4; o++) begin
            op(1'b0, be8s_pkg::BE8S_SZ_BYTE, o, 32'h0);
            check("byte load", rd, 32'hA0 + o);
        end
        $display("test byte lanes finished");
    endtask
    task automatic t_half();
        op(1'b1, be8s_pkg::BE8S_SZ_HALF, 32'h6, 32'h7777_B0B1);
        check("half be hi", {28'h0, wr_be}, 32'hC);
        check("half lanes hi", {16'h0, wr_d[31:16]}, 32'hB1B0);
        op(1'b1, be8s_pkg::BE8S_SZ_HALF, 32'h5, 32'h0000_C0C1);
        check("half be lo", {28'h0, wr_be}, 32'h3);
        check("half lanes lo", {16'h0, wr_d[15:0]}, 32'hC1C0);
        op(1'b0, be8s_pkg::BE8S_SZ_WORD, 32'h4, 32'h0);
        check("word load", rd, 32'hC0C1_B0B1);
        op(1'b0, be8s_pkg::BE8S_SZ_HALF, 32'h7, 32'h0);
        check("half load", rd, 32'h0000_B0B1);
        $display("test halfwords finished");
    endtask
    task automatic t_word_slow();
        @(posedge CLK);
        slow <= 1'b1;
        op(1'b1, be8s_pkg::BE8S_SZ_WORD, 32'hFFFF_F022, 32'h1122_3344);
        check("word be", {28'h0, wr_be}, 32'hF);
        check("word lanes", wr_d, 32'h4433_2211);
        check("word addr", wr_a, 32'hFFFF_F020);
        op(1'b0, be8s_pkg::BE8S_SZ_WORD, 32'hFFFF_F020, 32'h0);
        check("periph load", rd, 32'h1122_3344);
        op(1'b0, be8s_pkg::BE8S_SZ_BYTE, 32'hFFFF_F021, 32'h0);
        check("periph byte", rd, 32'h22);
        @(posedge CLK);
        slow <= 1'b0;
        $display("test slow peripheral words finished");
    endtask
    initial begin
        repeat (3) @(posedge CLK);
        check("reset ready", {31'h0, CORE_READY}, 32'h1);
        check("reset bus", {31'h0, BUS_CMD.read | BUS_CMD.write}, 32'h0);
        repeat (3) @(posedge CLK);
        RESET_N <= 1'b1;
        t_byte();
        t_half();
        t_word_slow();
        finish_test();
    end
    // The whole run needs about 65 cycles; the limit leaves ample margin.
    initial begin
        #50000;
        n_errors++;
        $display("[ERR] watchdog expected finish seen hang");
        finish_test();
    end
endmodule
